// [core/iap_flash_unlock_erase_addr.sv]
// top of the self-programming front end: registers, unlock and erase decode
`default_nettype none
module iap_flash_unlock_erase_addr #(
  parameter int unsigned HIGH_BITS = iap_pkg::HIGH_BITS_DEFAULT,
  parameter int unsigned SLOW_INTERNAL_RC_OSC_HZ = iap_pkg::SLOW_INTERNAL_RC_OSC_HZ_DEFAULT
) (
  // clock and reset
  input wire logic clock,
  input wire logic resetn,
  // data memory port
  input wire logic [7:0] sfrAddr,
  input wire logic sfrWrite,
  input wire logic sfrRead,
  input wire logic [7:0] sfrWdata,
  output logic [7:0] sfrRdata,
  // flash array
  output logic opStart,
  output logic [2:0] opMode,
  output logic [HIGH_BITS+7:0] flashAddr,
  output logic [63:0] flashData,
  output logic [iap_pkg::ERASE_W-1:0] eraseIndex,
  output logic writeEnabled,
  input wire logic opDone,
  output logic bufClearReq,
  input wire logic bufClearDone
);
  import iap_pkg::*;

  // ==================================================
  // derived constants
  localparam int unsigned AW = HIGH_BITS + 8;
  localparam int unsigned TICK_DIV = CLOCK_HZ / SLOW_INTERNAL_RC_OSC_HZ;
  localparam int unsigned RAW_TICKS = (TIMEOUT_US * SLOW_INTERNAL_RC_OSC_HZ) / US_PER_S;
  localparam int unsigned TIMEOUT_TICKS = (RAW_TICKS < 1) ? 1 : RAW_TICKS;
  localparam int unsigned ERASE_SHIFT = (HIGH_BITS <= BLOCK_HIGH_BITS) ? BLOCK_SHIFT
    : (HIGH_BITS == PAGE32_HIGH_BITS) ? PAGE32_SHIFT : PAGE64_SHIFT;

  // ==================================================
  // state
  logic write_enabled_flag_q, write_enabled_flag_d;
  logic unlock_procedure_enable_q, unlock_procedure_enable_d;
  logic fwt_q, fwt_d;
  logic rden_q, rden_d;
  logic rd_q, rd_d;
  logic clear_q, clear_d;
  mode_type mode_q, mode_d;
  logic [7:0] addrLow_q, addrLow_d;
  logic [HIGH_BITS-1:0] addrHigh_q, addrHigh_d;
  logic [7:0] rdata_q, rdata_d;
  logic [7:0] dataBytes_q [8];
  logic lircTick;

  // ==================================================
  // address decode
  wire logic ctrlWe = sfrWrite && (sfrAddr == ADDR_CTRL0);
  wire logic clearWe = sfrWrite && (sfrAddr == ADDR_CLEAR);
  wire logic lowWe = sfrWrite && (sfrAddr == ADDR_ALOW);
  wire logic highWe = sfrWrite && (sfrAddr == ADDR_AHIGH);
  wire logic dataHit = (sfrAddr >= ADDR_DATA0) && (sfrAddr <= ADDR_DATA_LAST);
  wire logic [7:0] dataOff = sfrAddr - ADDR_DATA0;
  wire logic [2:0] dataSlot = dataOff[2:0];
  wire logic dataWe = sfrWrite && dataHit;
  wire logic fwtSet = ctrlWe && sfrWdata[START_BIT];
  wire logic rdSet = ctrlWe && sfrWdata[RD_BIT];

  // ==================================================
  // unlock attempt
  unlock_if unlock ();
  assign unlock.arm = unlock_procedure_enable_q && (mode_q == MODE_UNLOCK);
  assign unlock.byteStrobe = dataWe;
  assign unlock.byteSlot = dataSlot - PATTERN_SLOT0;
  assign unlock.byteData = sfrWdata;
  assign unlock.lircTick = lircTick;
  wire logic unlockPass = unlock.pass;
  wire logic unlockFail = unlock.fail;

  slow_internal_rc_osc_tick_div #(
    .DIV(TICK_DIV)
  ) u_tick (
    .clock(clock),
    .resetn(resetn),
    .tick(lircTick)
  );

  unlock_checker #(
    .TIMEOUT_TICKS(TIMEOUT_TICKS)
  ) u_check (
    .clock(clock),
    .resetn(resetn),
    .link(unlock)
  );

  // ==================================================
  // flash operation gating
  wire logic progMode = (mode_q == MODE_WRITE) || (mode_q == MODE_ERASE);
  wire logic progOk = progMode && write_enabled_flag_q;
  wire logic readOk = (mode_q == MODE_READ) && rden_q;
  wire logic fwtBlocked = fwt_q && !progOk;
  wire logic rdBlocked = rd_q && !readOk;
  assign opStart = (fwt_q && progOk) || (rd_q && readOk);

  // ==================================================
  // next values
  assign write_enabled_flag_d = unlockPass ? 1'b1
    : (ctrlWe && !sfrWdata[WEN_BIT]) ? 1'b0 : write_enabled_flag_q;
  assign unlock_procedure_enable_d = (unlockPass || unlockFail) ? 1'b0
    : ctrlWe ? sfrWdata[PROC_BIT] : unlock_procedure_enable_q;
  assign fwt_d = fwtSet ? 1'b1
    : (opDone || fwtBlocked || ctrlWe) ? 1'b0 : fwt_q;
  assign rd_d = rdSet ? 1'b1 : (opDone || rdBlocked || ctrlWe) ? 1'b0 : rd_q;
  assign rden_d = ctrlWe ? sfrWdata[RDEN_BIT] : rden_q;
  assign mode_d = ctrlWe ? mode_type'(sfrWdata[MODE_HI:MODE_LO]) : mode_q;
  assign clear_d = clearWe ? sfrWdata[CLEAR_BIT]
    : bufClearDone ? 1'b0 : clear_q;
  assign addrLow_d = lowWe ? sfrWdata : addrLow_q;
  assign addrHigh_d = highWe ? sfrWdata[HIGH_BITS-1:0] : addrHigh_q;

  // ==================================================
  // read view
  wire logic [7:0] ctrlView = {write_enabled_flag_q, mode_q, unlock_procedure_enable_q, fwt_q, rden_q, rd_q};
  wire logic [7:0] clearView = {7'h00, clear_q};
  wire logic [7:0] highView = 8'(addrHigh_q);
  wire logic [7:0] dataView = dataBytes_q[dataSlot];
  wire logic [7:0] readValue = (sfrAddr == ADDR_CTRL0) ? ctrlView
    : (sfrAddr == ADDR_CLEAR) ? clearView
    : (sfrAddr == ADDR_ALOW) ? addrLow_q
    : (sfrAddr == ADDR_AHIGH) ? highView
    : dataHit ? dataView : BYTE_RESET;
  assign rdata_d = sfrRead ? readValue : rdata_q;

  // ==================================================
  // control registers
  always_ff @(posedge clock) begin
    if (!resetn) begin
      write_enabled_flag_q <= 1'b0;
      unlock_procedure_enable_q <= 1'b0;
      fwt_q <= 1'b0;
      rden_q <= 1'b0;
      rd_q <= 1'b0;
      mode_q <= MODE_RESET;
      clear_q <= 1'b0;
    end else begin
      write_enabled_flag_q <= write_enabled_flag_d;
      unlock_procedure_enable_q <= unlock_procedure_enable_d;
      fwt_q <= fwt_d;
      rden_q <= rden_d;
      rd_q <= rd_d;
      mode_q <= mode_d;
      clear_q <= clear_d;
    end
  end

  always_ff @(posedge clock) begin
    if (!resetn) begin
      addrLow_q <= BYTE_RESET;
      addrHigh_q <= '0;
      rdata_q <= BYTE_RESET;
    end else begin
      addrLow_q <= addrLow_d;
      addrHigh_q <= addrHigh_d;
      rdata_q <= rdata_d;
    end
  end

  // ==================================================
  // data word bytes
  for (genvar i = 0; i < 8; i++) begin : g_data
    always_ff @(posedge clock) begin
      if (!resetn) begin
        dataBytes_q[i] <= BYTE_RESET;
      end else if (dataWe && (dataSlot == 3'(i))) begin
        dataBytes_q[i] <= sfrWdata;
      end
    end
    assign flashData[8*i +: 8] = dataBytes_q[i];
  end

  // ==================================================
  // outputs and erase decode
  wire logic [AW-1:0] fullAddr = {addrHigh_q, addrLow_q};
  assign flashAddr = fullAddr;
  assign eraseIndex = ERASE_W'(fullAddr >> ERASE_SHIFT);
  assign opMode = mode_q;
  assign writeEnabled = write_enabled_flag_q;
  assign bufClearReq = clear_q;
  assign sfrRdata = rdata_q;

  // ==================================================
  // checks
  default clocking cb @(posedge clock); endclocking
  default disable iff (!resetn);

  sequence s_clearSet;
    clearWe && sfrWdata[CLEAR_BIT];
  endsequence
  sequence s_clearDone;
    bufClearReq && bufClearDone && !clearWe;
  endsequence
  property p_clear_start;
    s_clearSet |=> bufClearReq;
  endproperty
  a_clear_start: assert property (p_clear_start) else $error("clear did not start");
  property p_clear_end;
    s_clearDone |=> !bufClearReq;
  endproperty
  a_clear_end: assert property (p_clear_end) else $error("clear bit not returned");

  property p_clear_upper;
    sfrRead && (sfrAddr == ADDR_CLEAR) |=> sfrRdata[7:1] == 7'h00;
  endproperty
  a_clear_upper: assert property (p_clear_upper) else $error("clear upper bits set");

  property p_high_zero;
    sfrRead && (sfrAddr == ADDR_AHIGH) |=> (sfrRdata >> HIGH_BITS) == BYTE_RESET;
  endproperty
  a_high_zero: assert property (p_high_zero) else $error("unused address bits set");

  sequence s_dataRoundTrip;
    dataWe ##1 (sfrRead && !sfrWrite && (sfrAddr == $past(sfrAddr)));
  endsequence
  property p_data_back;
    s_dataRoundTrip |=> sfrRdata == $past(sfrWdata, 2);
  endproperty
  a_data_back: assert property (p_data_back) else $error("data byte lost");

  property p_pass;
    unlockPass |=> writeEnabled && !unlock_procedure_enable_q;
  endproperty
  a_pass: assert property (p_pass) else $error("unlock pass not applied");

  property p_fail;
    unlockFail && !unlockPass |=> !unlock_procedure_enable_q && !$rose(writeEnabled);
  endproperty
  a_fail: assert property (p_fail) else $error("unlock fail not applied");

  property p_no_soft_set;
    !writeEnabled && !unlockPass |=> !writeEnabled;
  endproperty
  a_no_soft_set: assert property (p_no_soft_set) else $error("flag set without unlock");

  property p_blocked;
    fwt_q && !progOk && !fwtSet |=> !fwt_q && !opStart;
  endproperty
  a_blocked: assert property (p_blocked) else $error("locked write not refused");

  property p_done_clears;
    opDone && fwt_q && !fwtSet |=> !fwt_q;
  endproperty
  a_done_clears: assert property (p_done_clears) else $error("start bit not cleared");

  property p_block_low_ignored;
    lowWe && !highWe && (HIGH_BITS == BLOCK_HIGH_BITS) |=> $stable(eraseIndex);
  endproperty
  a_block_low_ignored: assert property (p_block_low_ignored) else $error("block moved");

  property p_page_unit;
    highWe |=> (eraseIndex >> (BLOCK_SHIFT - ERASE_SHIFT))
      == ERASE_W'($past(sfrWdata[HIGH_BITS-1:0]));
  endproperty
  a_page_unit: assert property (p_page_unit) else $error("erase unit misdecoded");
endmodule // iap_flash_unlock_erase_addr
`default_nettype wire

// [core/iap_pkg.sv]
// constants, modes and register map of the self-programming front end
`default_nettype none
// ==================================================
package iap_pkg;
  // ==================================================
  // register addresses in data memory sector zero
  localparam logic [7:0] ADDR_CTRL0 = 8'h50;
  localparam logic [7:0] ADDR_CLEAR = 8'h52;
  localparam logic [7:0] ADDR_ALOW = 8'h53;
  localparam logic [7:0] ADDR_AHIGH = 8'h54;
  localparam logic [7:0] ADDR_DATA0 = 8'h55;
  localparam logic [7:0] ADDR_DATA_LAST = 8'h5C;
  // ==================================================
  // field positions and reset values
  localparam int unsigned WEN_BIT = 7;
  localparam int unsigned MODE_HI = 6;
  localparam int unsigned MODE_LO = 4;
  localparam int unsigned PROC_BIT = 3;
  localparam int unsigned START_BIT = 2;
  localparam int unsigned RDEN_BIT = 1;
  localparam int unsigned RD_BIT = 0;
  localparam int unsigned CLEAR_BIT = 0;
  localparam logic [7:0] BYTE_RESET = 8'h00;
  // ==================================================
  // operation modes
  typedef enum logic [2:0] {
    MODE_WRITE = 3'h0,
    MODE_ERASE = 3'h1,
    MODE_READ = 3'h3,
    MODE_UNLOCK = 3'h6,
    MODE_RESET = 3'h7
  } mode_type;
  // ==================================================
  // unlock pattern, first byte in the low lane
  localparam logic [47:0] UNLOCK_PATTERN = 48'h40C3090D0400;
  localparam logic [2:0] PATTERN_LAST = 3'h5;
  localparam logic [2:0] PATTERN_SLOT0 = 3'h2;
  // ==================================================
  // timing
  localparam int unsigned CLOCK_HZ = 125_000_000;
  localparam int unsigned SLOW_INTERNAL_RC_OSC_HZ_DEFAULT = 32_000;
  localparam int unsigned TIMEOUT_US = 300;
  localparam int unsigned US_PER_S = 1_000_000;
  // ==================================================
  // memory sizes and erase units
  localparam int unsigned HIGH_BITS_DEFAULT = 7;
  localparam int unsigned BLOCK_HIGH_BITS = 4;
  localparam int unsigned PAGE32_HIGH_BITS = 5;
  localparam int unsigned BLOCK_SHIFT = 8;
  localparam int unsigned PAGE32_SHIFT = 5;
  localparam int unsigned PAGE64_SHIFT = 6;
  localparam int unsigned ERASE_W = 9;
endpackage
`default_nettype wire

// [core/slow_internal_rc_osc_tick_div.sv]
// divider giving one-cycle slow oscillator ticks
`default_nettype none
module slow_internal_rc_osc_tick_div #(
  parameter int unsigned DIV = 3906
) (
  // clock and reset
  input wire logic clock,
  input wire logic resetn,
  // slow tick
  output logic tick
);
  localparam int unsigned CW = $clog2(DIV + 1);
  logic [CW-1:0] count_q;
  logic tick_q;
  wire logic wrap = (count_q == CW'(DIV - 1));
  always_ff @(posedge clock) begin
    if (!resetn) begin
      count_q <= '0;
      tick_q <= 1'b0;
    end else begin
      count_q <= wrap ? '0 : count_q + 1'b1;
      tick_q <= wrap;
    end
  end
  assign tick = tick_q;
endmodule // slow_internal_rc_osc_tick_div
`default_nettype wire

// [core/unlock_checker.sv]
// unlock pattern checker with slow-tick timeout
`default_nettype none
module unlock_checker #(
  parameter int unsigned TIMEOUT_TICKS = 9
) (
  // clock and reset
  input wire logic clock,
  input wire logic resetn,
  // front end
  unlock_if.chk link
);
  import iap_pkg::*;
  localparam int unsigned TW = $clog2(TIMEOUT_TICKS + 1);
  typedef enum logic [1:0] {IDLE, RUN, HOLD} unlock_state_type;
  unlock_state_type state_q, state_d;
  logic [2:0] step_q, step_d;
  logic [TW-1:0] ticks_q, ticks_d;
  logic pass_q, fail_q;
  wire logic [7:0] expectByte = UNLOCK_PATTERN[{step_q, 3'b000} +: 8];
  wire logic running = (state_q == RUN) && link.arm;
  wire logic byteOk = (link.byteSlot == step_q) && (link.byteData == expectByte);
  wire logic timeout = link.lircTick && (ticks_q == TW'(TIMEOUT_TICKS - 1));
  wire logic passNow = running && link.byteStrobe && byteOk && (step_q == PATTERN_LAST) && !timeout;
  wire logic failNow = running && (timeout || (link.byteStrobe && !byteOk));
  // ==================================================
  // attempt sequencing
  always_comb begin
    state_d = state_q;
    step_d = step_q;
    ticks_d = ticks_q;
    case (state_q)
      IDLE: begin
        step_d = 3'h0;
        ticks_d = '0;
        if (link.arm) begin
          state_d = RUN;
        end
      end
      RUN: begin
        if (!link.arm) begin
          state_d = IDLE;
          step_d = 3'h0;
          ticks_d = '0;
        end else if (passNow || failNow) begin
          state_d = HOLD;
          step_d = 3'h0;
          ticks_d = '0;
        end else begin
          if (link.byteStrobe) begin
            step_d = step_q + 3'h1;
          end
          if (link.lircTick) begin
            ticks_d = ticks_q + 1'b1;
          end
        end
      end
      HOLD: begin
        step_d = 3'h0;
        ticks_d = '0;
        if (!link.arm) begin
          state_d = IDLE;
        end
      end
      default: state_d = IDLE;
    endcase
  end
  always_ff @(posedge clock) begin
    if (!resetn) begin
      state_q <= IDLE;
      step_q <= 3'h0;
      ticks_q <= '0;
      pass_q <= 1'b0;
      fail_q <= 1'b0;
    end else begin
      state_q <= state_d;
      step_q <= step_d;
      ticks_q <= ticks_d;
      pass_q <= passNow;
      fail_q <= failNow;
    end
  end
  assign link.pass = pass_q;
  assign link.fail = fail_q;
  // ==================================================
  // checks
  default clocking cb @(posedge clock); endclocking
  default disable iff (!resetn);
  property p_wrong_byte;
    running && link.byteStrobe && !byteOk |=> fail_q && !pass_q;
  endproperty
  a_wrong_byte: assert property (p_wrong_byte) else $error("bad byte did not abort");
  property p_timeout;
    running && timeout |=> fail_q ##1 (state_q != RUN);
  endproperty
  a_timeout: assert property (p_timeout) else $error("timeout did not fail");
  property p_idle_ticks;
    state_q != RUN |-> ticks_q == '0;
  endproperty
  a_idle_ticks: assert property (p_idle_ticks) else $error("ticks ran outside attempt");
endmodule // unlock_checker
`default_nettype wire

// [core/unlock_if.sv]
// link between register front end and unlock checker
`default_nettype none
interface unlock_if;
  logic arm;
  logic byteStrobe;
  logic [2:0] byteSlot;
  logic [7:0] byteData;
  logic lircTick;
  logic pass;
  logic fail;
  modport ctrl(output arm, byteStrobe, byteSlot, byteData, lircTick, input pass, fail);
  modport chk(input arm, byteStrobe, byteSlot, byteData, lircTick, output pass, fail);
endinterface
`default_nettype wire

// [verif/iap_flash_unlock_erase_addr_test.sv]
// self-checking bench of the self-programming front end
`default_nettype none
module iap_flash_unlock_erase_addr_test;
  timeunit 1ns;
  timeprecision 1ns;
  import iap_pkg::*;
  // ==================================================
  // settings and signals
  localparam int unsigned HB = 5;
  localparam int unsigned LHZ = 12_500_000;
  localparam int CYCLE_LIMIT = 40000;
  logic clock = 1'b0;
  logic resetn = 1'b0;
  logic [7:0] sfrAddr = 8'h00;
  logic sfrWrite = 1'b0;
  logic sfrRead = 1'b0;
  logic [7:0] sfrWdata = 8'h00;
  logic [7:0] sfrRdata;
  logic opStart;
  logic [2:0] opMode;
  logic [HB+7:0] flashAddr;
  logic [63:0] flashData;
  logic [ERASE_W-1:0] eraseIndex;
  logic writeEnabled;
  logic opDone = 1'b0;
  logic bufClearReq;
  logic bufClearDone = 1'b0;
  logic [7:0] rdv;
  int miscompares = 0;
  int samplesChecked = 0;
  int cycles = 0;
  logic [7:0] pat [6] = '{8'h00, 8'h04, 8'h0D, 8'h09, 8'hC3, 8'h40};
  // ==================================================
  // device under test
  iap_flash_unlock_erase_addr #(.HIGH_BITS(HB), .SLOW_INTERNAL_RC_OSC_HZ(LHZ)) iap_flash_unlock_erase_addr_inst (
    .clock(clock), .resetn(resetn), .sfrAddr(sfrAddr), .sfrWrite(sfrWrite), .sfrRead(sfrRead),
    .sfrWdata(sfrWdata), .sfrRdata(sfrRdata), .opStart(opStart), .opMode(opMode),
    .flashAddr(flashAddr), .flashData(flashData), .eraseIndex(eraseIndex),
    .writeEnabled(writeEnabled), .opDone(opDone), .bufClearReq(bufClearReq),
    .bufClearDone(bufClearDone));
  always #4 clock = ~clock;
  always @(posedge clock) begin
    cycles <= cycles + 1;
    if (cycles == CYCLE_LIMIT) begin
      miscompares = miscompares + 1;
      stop_test();
    end
  end
  // ==================================================
  // shared tasks
  task automatic check(input string what, input logic [63:0] seen, input logic [63:0] exp);
    samplesChecked = samplesChecked + 1;
    if (seen !== exp) begin
      miscompares = miscompares + 1;
      $display("[FAIL] %s expected %h seen %h", what, exp, seen);
    end
  endtask
  task automatic stop_test();
    $display("comparisons %0d mismatches %0d", samplesChecked, miscompares);
    if (miscompares == 0 && samplesChecked > 0) begin
      $display("STATUS OK");
    end else begin
      $display("STATUS NOT OK");
    end
    $finish;
  endtask
  task automatic idle(input int n);
    repeat (n) @(negedge clock);
  endtask
  task automatic wr(input logic [7:0] a, input logic [7:0] d);
    @(negedge clock);
    sfrAddr = a;
    sfrWdata = d;
    sfrWrite = 1'b1;
    @(negedge clock);
    sfrWrite = 1'b0;
  endtask
  task automatic rd(input logic [7:0] a, output logic [7:0] d);
    @(negedge clock);
    sfrAddr = a;
    sfrRead = 1'b1;
    @(negedge clock);
    sfrRead = 1'b0;
    d = sfrRdata;
  endtask
  task automatic rdCheck(input string what, input logic [7:0] a, input logic [7:0] exp);
    rd(a, rdv);
    check(what, {56'h0, rdv}, {56'h0, exp});
  endtask
  task automatic pulseDone();
    @(negedge clock);
    opDone = 1'b1;
    @(negedge clock);
    opDone = 1'b0;
  endtask
  // ==================================================
  // scenarios
  task automatic testReset();
    rdCheck("ctrl", ADDR_CTRL0, 8'h70);
    rdCheck("clear", ADDR_CLEAR, 8'h00);
    rdCheck("addrHigh", ADDR_AHIGH, 8'h00);
    for (int k = 0; k < 8; k++) begin
      rdCheck("dataByte", ADDR_DATA0 + 8'(k), 8'h00);
    end
    rdCheck("unmapped", 8'h51, 8'h00);
    check("opMode", 64'(opMode), 64'h7);
    check("writeEnabled", 64'(writeEnabled), 64'h0);
    $display("test reset done");
  endtask
  task automatic testAddress();
    wr(ADDR_ALOW, 8'hA5);
    wr(ADDR_AHIGH, 8'hFF);
    rdCheck("addrHigh", ADDR_AHIGH, 8'h1F);
    rdCheck("addrLow", ADDR_ALOW, 8'hA5);
    check("flashAddr", 64'(flashAddr), 64'h1FA5);
    check("eraseIndex", 64'(eraseIndex), 64'h0FD);
    wr(ADDR_ALOW, 8'hBA);
    check("eraseIndexLow", 64'(eraseIndex), 64'h0FD);
    $display("test address done");
  endtask
  task automatic testData();
    for (int k = 0; k < 8; k++) begin
      wr(ADDR_DATA0 + 8'(k), 8'h11 * 8'(k + 1));
    end
    check("flashData", flashData, 64'h8877665544332211);
    for (int k = 0; k < 8; k++) begin
      rdCheck("dataByte", ADDR_DATA0 + 8'(k), 8'h11 * 8'(k + 1));
    end
    $display("test data done");
  endtask
  task automatic testClear();
    wr(ADDR_CLEAR, 8'hFF);
    check("clearReq", 64'(bufClearReq), 64'h1);
    rdCheck("clearBusy", ADDR_CLEAR, 8'h01);
    idle(3);
    check("clearHeld", 64'(bufClearReq), 64'h1);
    @(negedge clock);
    bufClearDone = 1'b1;
    @(negedge clock);
    bufClearDone = 1'b0;
    idle(1);
    check("clearEnd", 64'(bufClearReq), 64'h0);
    rdCheck("clearIdle", ADDR_CLEAR, 8'h00);
    $display("test clear done");
  endtask
  task automatic testUnlockFail();
    wr(ADDR_CTRL0, 8'h80);
    idle(2);
    check("flagSet", 64'(writeEnabled), 64'h0);
    wr(ADDR_CTRL0, 8'h68);
    wr(ADDR_DATA0 + 8'h2, 8'h00);
    wr(ADDR_DATA0 + 8'h3, 8'h05);
    idle(3);
    check("badByte", 64'(writeEnabled), 64'h0);
    rdCheck("badCtrl", ADDR_CTRL0, 8'h60);
    wr(ADDR_CTRL0, 8'h68);
    wr(ADDR_DATA0 + 8'h3, 8'h04);
    for (int i = 1; i < 6; i++) begin
      wr(ADDR_DATA0 + 8'(2 + i), pat[i]);
    end
    idle(3);
    check("order", 64'(writeEnabled), 64'h0);
    rdCheck("orderCtrl", ADDR_CTRL0, 8'h60);
    wr(ADDR_CTRL0, 8'h68);
    rdCheck("armed", ADDR_CTRL0, 8'h68);
    idle(37000);
    rdCheck("beforeTimeout", ADDR_CTRL0, 8'h68);
    idle(600);
    rdCheck("timeoutCtrl", ADDR_CTRL0, 8'h60);
    check("timeoutFlag", 64'(writeEnabled), 64'h0);
    $display("test unlock fail done");
  endtask
  task automatic testUnlockPass();
    wr(ADDR_CTRL0, 8'h68);
    for (int i = 0; i < 6; i++) begin
      wr(ADDR_DATA0 + 8'(2 + i), pat[i]);
    end
    idle(3);
    check("passFlag", 64'(writeEnabled), 64'h1);
    rdCheck("passCtrl", ADDR_CTRL0, 8'hE0);
    $display("test unlock pass done");
  endtask
  task automatic runOp(input logic [7:0] c, input logic [2:0] m, input logic [7:0] after);
    wr(ADDR_CTRL0, c);
    check("opStart", 64'(opStart), 64'h1);
    check("opMode", 64'(opMode), 64'(m));
    idle(2);
    check("opHeld", 64'(opStart), 64'h1);
    pulseDone();
    idle(1);
    check("opEnd", 64'(opStart), 64'h0);
    rdCheck("opCtrl", ADDR_CTRL0, after);
  endtask
  task automatic testOps();
    runOp(8'h94, 3'h1, 8'h90);
    runOp(8'h84, 3'h0, 8'h80);
    wr(ADDR_CTRL0, 8'h00);
    check("disabled", 64'(writeEnabled), 64'h0);
    wr(ADDR_CTRL0, 8'h04);
    check("blocked", 64'(opStart), 64'h0);
    idle(1);
    rdCheck("blockedCtrl", ADDR_CTRL0, 8'h00);
    runOp(8'h33, 3'h3, 8'h32);
    $display("test operations done");
  endtask
  // ==================================================
  // main sequence
  initial begin
    repeat (3) @(negedge clock);
    resetn = 1'b1;
    testReset();
    testAddress();
    testData();
    testClear();
    testUnlockFail();
    testUnlockPass();
    testOps();
    stop_test();
  end
endmodule // iap_flash_unlock_erase_addr_test
`default_nettype wire
